// ==== hw/smsp_core.sv ====
// Switch monitor serial port, interrupt and poll synchronisation
//
// Contract
// [R1] CS fall: drive SO, snapshot status
// [R2] CS rise: release SO, clear INT, apply
// [R3] Host moves CS only with SCLK low
// [R4] Shift SI in on SCLK rise
// [R5] Next SO bit on SCLK fall
// [R6] Deselected: ignore SCLK, SI; SO off
// [R7] Host should park SCLK low when idle
// [R8] Sixteen bits per command; high is one
// [R9] Open reads zero, closed reads one
// [R10] CS fall shows bit 15 first
// [R11] Both words travel MSB first
// [R12] Chained pair needs 32 clocks
// [R13] Status holds switches, master, flag, mode
// [R14] Master runs oscillator, slave stops it
// [R15] Master times polls, signals slave
// [R16] Normal mode: change drives INT
// [R17] INT flag is inverse latched pin
// [R18] Polling: INT only during sampling
// [R19] Reset pin clears all, enters sleep
// [R20] Only a command leaves sleep
// [R21] Drop wetting current after 20 ms
// [R22] Status shows previous configuration
// [R23] Power-up clears, enters sleep
// [R24] Polling: closed switch interrupts, goes normal
// [R25] Synchronise pins, detect edges
`default_nettype none

module smsp_core #(
  parameter int NUM_SW     = smsp_pkg::NUM_SW,
  parameter int WET_CYC    = int'(smsp_pkg::WET_CYCLES),
  parameter int POLL_CYC   = int'(smsp_pkg::POLL_CYCLES),
  parameter int SAMP_CYC   = int'(smsp_pkg::SAMP_CYCLES),
  parameter int INT_POLLS  = smsp_pkg::INT_TMR_POLLS
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              cs_n_pin,
  input  wire logic              sclk_pin,
  input  wire logic              si_pin,
  output logic                   so_o,
  output logic                   so_oe,
  input  wire logic              rst_n_pin,
  output logic                   int_n_o,
  output logic                   int_n_oe,
  input  wire logic              master_slave_select,
  input  wire logic              sync_pin,
  output logic                   sync_o,
  input  wire logic [NUM_SW-1:0] switch_closed_pin,
  output logic [NUM_SW-1:0]      wet_high,
  output logic                   sense_enable,
  output logic                   osc_run,
  output logic [1:0]             mode_code,
  output logic [11:0]            run_cfg,
  output logic [11:0]            metal_cfg,
  output logic [11:0]            tri_mask
);

  localparam int CW = smsp_pkg::CMD_W;

  initial begin
    if (NUM_SW != smsp_pkg::NUM_SW) $error("smsp_core: NUM_SW fixed");
    if (POLL_CYC < 2 || SAMP_CYC < 1 || INT_POLLS < 1) begin
      $error("smsp_core: poll timing out of range");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    smsp_pkg::smsp_mode_t mode;
    logic                 cs_q;
    logic                 sclk_q;
    logic                 sel;
    logic [5:0]           bitcnt;
    logic [CW-1:0]        rx;
    logic [CW-1:0]        tx;
    logic                 int_act;
    logic [NUM_SW-1:0]    sw;
    logic [11:0]          run_c;
    logic [11:0]          metal_c;
    logic [11:0]          tri_m;
    logic [31:0]          poll_cnt;
    logic                 window;
    logic [15:0]          int_polls;
  } smsp_core_t;

  smsp_core_t s_reg;
  smsp_core_t s_next;

  localparam smsp_core_t RESET_VAL = '{
    mode: smsp_pkg::SMSP_SLEEP, cs_q: 1'b1, default: '0}; // [R23]

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic              cs_s;
  logic              sclk_s;
  logic              si_s;
  logic              rst_n_s;
  logic              master_slave_select_s;
  logic              sync_s;
  logic [NUM_SW-1:0] sw_s;

  smsp_sync #(.W(6), .INIT(6'h09)) u_sync_ctl ( // [R25]
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({sync_pin, master_slave_select, rst_n_pin,
               si_pin, sclk_pin, cs_n_pin}),
    .q       ({sync_s, master_slave_select_s, rst_n_s, si_s, sclk_s, cs_s})
  );

  smsp_sync #(.W(NUM_SW), .INIT('0)) u_sync_sw (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (switch_closed_pin),
    .q       (sw_s)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] mode_enc(smsp_pkg::smsp_mode_t m);
    unique case (m)
      smsp_pkg::SMSP_POLL:     mode_enc = smsp_pkg::MOD_POLL;
      smsp_pkg::SMSP_POLL_TMR: mode_enc = smsp_pkg::MOD_POLL_TMR;
      smsp_pkg::SMSP_NORMAL:   mode_enc = smsp_pkg::MOD_NORMAL;
      smsp_pkg::SMSP_SLEEP:    mode_enc = smsp_pkg::MOD_NORMAL;
    endcase
  endfunction

  function automatic logic is_poll(smsp_pkg::smsp_mode_t m);
    is_poll = (m == smsp_pkg::SMSP_POLL) ||
              (m == smsp_pkg::SMSP_POLL_TMR);
  endfunction

  // ****************************************
  // Derived terms
  // ****************************************
  logic              cs_fall;
  logic              cs_rise;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              word_ok;
  logic              sensing;
  logic [NUM_SW-1:0] sw_live;
  logic [CW-1:0]     status;
  logic [3:0]        op;

  assign cs_fall   = s_reg.cs_q && !cs_s;                  // [R25]
  assign cs_rise   = !s_reg.cs_q && cs_s;
  assign sclk_rise = !s_reg.sclk_q && sclk_s && s_reg.sel; // [R6]
  assign sclk_fall = s_reg.sclk_q && !sclk_s && s_reg.sel; // [R6]
  // Accept 16 bits, or 32 or 48 when chained; last word is ours
  assign word_ok   = (s_reg.bitcnt != 6'h00) &&
                     ((s_reg.bitcnt[3:0] & smsp_pkg::WORD_MASK) == 4'h0)
                     && (s_reg.bitcnt != smsp_pkg::BITCNT_MAX); // [R8] [R12]
  assign op        = s_reg.rx[smsp_pkg::OP_HI:smsp_pkg::OP_LO];
  // Comparators only active while sense currents flow
  assign sensing   = (s_reg.mode == smsp_pkg::SMSP_NORMAL) ||
                     (is_poll(s_reg.mode) && s_reg.window);
  assign sw_live   = sw_s & ~s_reg.tri_m;                  // [R9]

  always_comb begin
    status = '0;
    status[NUM_SW-1:0] = s_reg.sw;                         // [R9]
    status[smsp_pkg::ST_MODE_HI:smsp_pkg::ST_MODE_LO] =
      mode_enc(s_reg.mode);                                // [R13]
    status[smsp_pkg::ST_MASTER_SLAVE_SELECT] = master_slave_select_s;
    status[smsp_pkg::ST_INT]  = s_reg.int_act;             // [R17]
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next        = s_reg;
    s_next.cs_q   = cs_s;
    s_next.sclk_q = sclk_s;

    // Serial shifting
    if (cs_fall) begin
      s_next.sel    = 1'b1;                                // [R1]
      s_next.tx     = status;                              // [R1] [R10]
      s_next.bitcnt = '0;
      s_next.rx     = '0;
    end else if (s_reg.sel) begin
      if (sclk_rise) begin
        s_next.rx = {s_reg.rx[CW-2:0], si_s};              // [R4] [R11]
        if (s_reg.bitcnt != smsp_pkg::BITCNT_MAX) begin
          s_next.bitcnt = s_reg.bitcnt + 6'h01;
        end
      end
      if (sclk_fall) begin
        s_next.tx = {s_reg.tx[CW-2:0], 1'b0};              // [R5] [R11]
      end
    end

    // Switch snapshot follows the pins only while deselected
    if (!s_reg.sel && !cs_fall) begin
      if (s_reg.mode == smsp_pkg::SMSP_SLEEP) begin
        s_next.sw = '0;
      end else if (sensing) begin
        s_next.sw = sw_live;                               // [R2]
      end
    end

    // Polling period and sampling window
    if (is_poll(s_reg.mode)) begin
      if (master_slave_select_s) begin
        if (s_reg.window) begin
          if (s_reg.poll_cnt >= 32'(SAMP_CYC - 1)) begin
            s_next.window   = 1'b0;
            s_next.poll_cnt = '0;
          end else begin
            s_next.poll_cnt = s_reg.poll_cnt + 32'h1;
          end
        end else if (s_reg.poll_cnt >= 32'(POLL_CYC - 1)) begin
          s_next.window   = 1'b1;                          // [R15]
          s_next.poll_cnt = '0;
        end else begin
          s_next.poll_cnt = s_reg.poll_cnt + 32'h1;
        end
      end else begin
        s_next.window   = sync_s;                          // [R15]
        s_next.poll_cnt = '0;
      end
      // Window end counts toward the wake-up interrupt timer
      if (s_reg.window && !s_next.window &&
          s_reg.mode == smsp_pkg::SMSP_POLL_TMR) begin
        s_next.int_polls = s_reg.int_polls + 16'h1;
      end
    end else begin
      s_next.window    = 1'b0;
      s_next.poll_cnt  = '0;
      s_next.int_polls = '0;
    end

    // Clear first so a same-cycle event still sets the flag
    if (cs_rise) begin
      s_next.int_act = 1'b0;                               // [R2]
    end
    if (s_reg.mode == smsp_pkg::SMSP_NORMAL && !s_reg.sel &&
        sw_live != s_reg.sw) begin
      s_next.int_act = 1'b1;                               // [R16]
    end
    if (is_poll(s_reg.mode) && s_reg.window) begin
      if (|sw_live) begin
        s_next.int_act = 1'b1;                             // [R18] [R24]
        s_next.mode    = smsp_pkg::SMSP_NORMAL;            // [R24]
      end else if (s_reg.mode == smsp_pkg::SMSP_POLL_TMR &&
                   s_reg.int_polls >= 16'(INT_POLLS)) begin
        s_next.int_act   = 1'b1;                           // [R18]
        s_next.int_polls = '0;
      end
    end

    // Command applied on deselect
    if (cs_rise) begin
      s_next.sel = 1'b0;                                   // [R2]
      if (word_ok) begin                                   // [R20]
        unique case (op)
          smsp_pkg::OP_SLEEP: begin
            s_next.mode = smsp_pkg::SMSP_SLEEP;
          end
          smsp_pkg::OP_RUN: begin
            s_next.run_c = s_reg.rx[11:0];                 // [R2]
            unique case (s_reg.rx[smsp_pkg::MOD_HI:smsp_pkg::MOD_LO])
              smsp_pkg::MOD_POLL:
                s_next.mode = smsp_pkg::SMSP_POLL;
              smsp_pkg::MOD_POLL_TMR:
                s_next.mode = smsp_pkg::SMSP_POLL_TMR;
              default:
                s_next.mode = smsp_pkg::SMSP_NORMAL;
            endcase
          end
          smsp_pkg::OP_TRI: begin
            s_next.tri_m = s_reg.rx[11:0];
            if (s_reg.mode == smsp_pkg::SMSP_SLEEP) begin
              s_next.mode = smsp_pkg::SMSP_NORMAL;         // [R20]
            end
          end
          smsp_pkg::OP_METAL: begin
            s_next.metal_c = s_reg.rx[11:0];
            if (s_reg.mode == smsp_pkg::SMSP_SLEEP) begin
              s_next.mode = smsp_pkg::SMSP_NORMAL;         // [R20]
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Reset pin wins over everything
    if (!rst_n_s) begin
      s_next = RESET_VAL;                                  // [R19]
      s_next.cs_q   = cs_s;
      s_next.sclk_q = sclk_s;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= RESET_VAL;                                  // [R23]
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Wetting current timers
  // ****************************************
  for (genvar g = 0; g < NUM_SW; g++) begin : g_wet
    smsp_wet_timer #(.CNT_W(32), .CYCLES(WET_CYC)) u_wet (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .clear    (!rst_n_s),                                // [R19]
      .closed   (s_reg.sw[g] && sensing),
      .wet_high (wet_high[g])                              // [R21]
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign so_o         = s_reg.tx[CW-1];                    // [R10] [R22]
  assign so_oe        = s_reg.sel;                         // [R1] [R6]
  assign int_n_o      = 1'b0;
  assign int_n_oe     = s_reg.int_act;                     // [R16]
  assign sync_o       = master_slave_select_s && is_poll(s_reg.mode) && s_reg.window;
  assign sense_enable = sensing;
  // Slave sleeps between polls to save supply current
  assign osc_run      = (s_reg.mode != smsp_pkg::SMSP_SLEEP) &&
                        (master_slave_select_s || !is_poll(s_reg.mode) ||
                         s_reg.window);                    // [R14]
  assign mode_code    = mode_enc(s_reg.mode);
  assign run_cfg      = s_reg.run_c;
  assign metal_cfg    = s_reg.metal_c;
  assign tri_mask     = s_reg.tri_m;

endmodule

`default_nettype wire

// ==== hw/smsp_pkg.sv ====
// Shared constants and types of the switch monitor serial port
`default_nettype none

package smsp_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int          CMD_W        = 16;
  localparam int          NUM_SW       = 12;
  localparam int          OP_HI        = 15;
  localparam int          OP_LO        = 12;
  localparam int          MOD_HI       = 11;
  localparam int          MOD_LO       = 10;
  localparam int          ST_MODE_HI   = 15;
  localparam int          ST_MODE_LO   = 14;
  localparam int          ST_MASTER_SLAVE_SELECT      = 13;
  localparam int          ST_INT       = 12;
  localparam logic [3:0]  OP_SLEEP     = 4'h0;
  localparam logic [3:0]  OP_RUN       = 4'h1;
  localparam logic [3:0]  OP_TRI       = 4'h3;
  localparam logic [3:0]  OP_METAL     = 4'h5;
  localparam logic [1:0]  MOD_NORMAL   = 2'h0;
  localparam logic [1:0]  MOD_POLL     = 2'h1;
  localparam logic [1:0]  MOD_POLL_TMR = 2'h2;
  localparam logic [5:0]  BITCNT_MAX   = 6'h3F;
  localparam logic [3:0]  WORD_MASK    = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint      CLK_HZ       = 50_000_000;
  localparam longint      WET_TIME_MS  = 20;
  localparam longint      WET_CYCLES   = (WET_TIME_MS * CLK_HZ + 999) / 1000;
  localparam longint      POLL_TIME_US = 1000;
  localparam longint      POLL_CYCLES  = (POLL_TIME_US * CLK_HZ) / 1000000;
  localparam longint      SAMP_TIME_US = 10;
  localparam longint      SAMP_CYCLES  = (SAMP_TIME_US * CLK_HZ) / 1000000;
  localparam int          INT_TMR_POLLS = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SMSP_SLEEP,
    SMSP_NORMAL,
    SMSP_POLL,
    SMSP_POLL_TMR
  } smsp_mode_t;

endpackage

`default_nettype wire

// ==== hw/smsp_sync.sv ====
// Three-stage input synchroniser with agreement filter
`default_nettype none

module smsp_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } smsp_sync_t;

  smsp_sync_t s_reg;
  smsp_sync_t s_next;

  initial begin
    if (W < 1) $error("smsp_sync: W must be at least 1");
  end

  // ****************************************
  // Filter
  // ****************************************
  always_comb begin
    s_next     = s_reg;
    s_next.ff1 = d;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    // Only stages two and three decide, ff1 may be metastable
    for (int i = 0; i < W; i++) begin
      if (s_reg.ff2[i] == s_reg.ff3[i]) begin
        s_next.q[i] = s_reg.ff3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '{ff1: INIT, ff2: INIT, ff3: INIT, q: INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;

endmodule

`default_nettype wire

// ==== hw/smsp_wet_timer.sv ====
// Per-input high wetting current timer
`default_nettype none

module smsp_wet_timer #(
  parameter int CNT_W  = 20,
  parameter int CYCLES = 1000000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clear,
  input  wire logic closed,
  output logic      wet_high
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } smsp_wet_t;

  smsp_wet_t s_reg;
  smsp_wet_t s_next;

  initial begin
    // Wide shift so a full-width counter does not wrap the bound
    if (CYCLES < 1 || longint'(CYCLES) >= (longint'(1) << CNT_W)) begin
      $error("smsp_wet_timer: CYCLES does not fit CNT_W");
    end
  end

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYCLES);

  always_comb begin
    s_next = s_reg;
    if (clear || !closed) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt != LIMIT) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // High current only until the closure has lasted the full time
  assign wet_high = closed && (s_reg.cnt != LIMIT); // [R21]

endmodule

`default_nettype wire

// ==== test/smsp_core_sva.sv ====
// Port assertions of the switch monitor serial port
`default_nettype none

module smsp_core_sva #(
  parameter int WET_CYC  = 50,
  parameter int POLL_CYC = 20
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cs_n_pin,
  input wire logic        sclk_pin,
  input wire logic        rst_n_pin,
  input wire logic        so_o,
  input wire logic        so_oe,
  input wire logic        int_n_oe,
  input wire logic        master_slave_select,
  input wire logic        sync_pin,
  input wire logic        sync_o,
  input wire logic [11:0] switch_closed_pin,
  input wire logic [11:0] wet_high,
  input wire logic        sense_enable,
  input wire logic        osc_run,
  input wire logic [1:0]  mode_code,
  input wire logic [11:0] run_cfg
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Ages since edges
  // ****************
  logic [3:0]  fall_reg;
  logic [3:0]  clr_reg;
  logic [15:0] hold_reg;
  logic [15:0] gap_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Ages saturate so a long idle never wraps into a false pass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fall_reg <= 4'hF;
      clr_reg  <= 4'hF;
      hold_reg <= 16'h0;
      gap_reg  <= 16'h0;
    end else begin
      fall_reg <= $fell(sclk_pin) ? 4'h0 : fall_reg + 4'(fall_reg != 4'hF);
      clr_reg  <= ($rose(cs_n_pin) || !rst_n_pin) ? 4'h0
                : clr_reg + 4'(clr_reg != 4'hF);
      hold_reg <= (!switch_closed_pin[0] || $rose(cs_n_pin)) ? 16'h0
                : hold_reg + 16'(hold_reg != 16'hFFFF);
      // Master idle time between sync pulses in plain polling mode (mode code 1)
      gap_reg  <= (sync_o || !master_slave_select || mode_code != 2'h1)
                ? 16'h0 : gap_reg + 16'(gap_reg != 16'hFFFF);
    end
  end

  chk_so_enable: assert property ($fell(cs_n_pin) |-> ##[3:6] so_oe)
    else $error("serial out not enabled after select");
  chk_so_release: assert property ($rose(cs_n_pin) |-> ##[1:6] !so_oe)
    else $error("serial out not released after deselect");
  chk_so_idle: assert property (cs_n_pin [*8] |-> !so_oe)
    else $error("serial out driven while deselected");
  chk_so_shift: assert property (
    so_oe && $past(so_oe) && $changed(so_o)
    |-> fall_reg inside {[4'h2:4'h6]})
    else $error("serial out moved without clock fall");
  chk_int_hold: assert property ($fell(int_n_oe) |-> clr_reg < 4'h8)
    else $error("interrupt dropped without deselect");
  chk_pin_reset: assert property (!rst_n_pin [*6]
    |-> mode_code == 2'h0 && run_cfg == 12'h0)
    else $error("reset pin did not clear state");
  chk_master_osc: assert property ((master_slave_select
    && mode_code == 2'h1) [*6] |-> osc_run)
    else $error("master oscillator stopped while polling");
  chk_slave_wake: assert property ((!master_slave_select && sync_pin
    && mode_code == 2'h1) [*6] |-> sense_enable)
    else $error("slave did not sample on sync");
  chk_sync_window: assert property (sync_o |-> sense_enable)
    else $error("sync raised outside sampling");
  chk_sync_period: assert property (
    gap_reg < 16'(2 * POLL_CYC))
    else $error("master sync pulse missing while polling");
  chk_poll_int: assert property ($rose(int_n_oe)
    && $past(mode_code) != 2'h0 |-> $past(sense_enable))
    else $error("polling interrupt outside sampling");
  chk_wet_drop: assert property (
    hold_reg > WET_CYC + 8 |-> !wet_high[0])
    else $error("wetting current kept high too long");
endmodule

bind smsp_core smsp_core_sva #(
  .WET_CYC(WET_CYC), .POLL_CYC(POLL_CYC)) u_sva (
  .clk, .sys_rst, .cs_n_pin, .sclk_pin, .rst_n_pin, .so_o, .so_oe,
  .int_n_oe, .master_slave_select, .sync_pin, .sync_o,
  .switch_closed_pin, .wet_high, .sense_enable, .osc_run, .mode_code,
  .run_cfg
);

`default_nettype wire

// ==== test/smsp_host.sv ====
// Host model that masters the serial link
`default_nettype none

module smsp_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // ******************************
  // One selection of n clock bits
  // ******************************
  // SO is taken late in the high phase: the port lags its pins
  task automatic xfer(input logic [15:0] cmd, input int n,
                      output logic [15:0] rx);
    rx = 16'h0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      si = cmd[15 - (i % 16)];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx = {rx[14:0], so};
      sclk = 1'b0;
    end
    si = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// ==== test/tb_smsp_core.sv ====
// Self-checking bench of the switch monitor serial port
`default_nettype none

module tb_smsp_core;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WET = 50;
  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        rst_n_pin = 1'b1;
  logic        master    = 1'b1;
  logic        sync_pin  = 1'b0;
  logic [11:0] sw        = 12'h0;
  logic [31:0] seed      = 32'hBC6D;
  logic        cs_n, sclk, si, so_pin, so_o, so_oe, int_n_o, int_n_oe;
  logic        sync_o, sense_enable, osc_run;
  logic [11:0] wet_high, run_cfg, metal_cfg, tri_mask;
  logic [1:0]  mode_code;
  logic [15:0] rx, cmd;
  int          failures  = 0;
  int          checks    = 0;
  int          n;

  always #10 clk = ~clk;
  // Released SO shows the inverse of its last bit, never a kind value
  assign so_pin = so_oe ? so_o : ~so_o;

  smsp_core #(.WET_CYC(WET), .POLL_CYC(20), .SAMP_CYC(4), .INT_POLLS(2)) uut (
    .clk, .sys_rst, .cs_n_pin(cs_n), .sclk_pin(sclk), .si_pin(si), .so_o,
    .so_oe, .rst_n_pin, .int_n_o, .int_n_oe, .master_slave_select(master),
    .sync_pin, .sync_o, .switch_closed_pin(sw), .wet_high, .sense_enable,
    .osc_run, .mode_code, .run_cfg, .metal_cfg, .tri_mask
  );
  smsp_host host (.clk(clk), .so(so_pin), .cs_n(cs_n), .sclk(sclk), .si(si));

  // ******************
  // Helpers
  // ******************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [15:0] status(input logic [1:0] m, input logic f,
                                         input logic [11:0] s);
    return {m, master, f, s};
  endfunction

  task automatic check(input string what, input logic [35:0] seen,
                       input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up(input int cnt);
    if (cnt >= 200) begin
      failures++;
      summarize();
    end
  endtask

  // ******************
  // Main sequence
  // ******************
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    seed = xs(seed);
    sw = seed[11:0] & 12'hFFE;
    repeat (20) @(negedge clk);
    check("sleep int", int_n_oe, 1'b0);
    host.xfer(16'h0000, 16, rx);
    check("sleep status", rx, status(2'h0, 1'b0, 12'h0));
    seed = xs(seed);
    cmd = {4'h1, 2'h0, seed[9:0]};
    host.xfer(cmd, 16, rx);
    check("run cfg", run_cfg, cmd[11:0]);
    check("mode", mode_code, 2'h0);
    host.xfer(cmd, 16, rx);
    host.xfer(cmd, 16, rx);
    check("steady status", rx, status(2'h0, 1'b0, sw));
    seed = xs(seed);
    sw = sw ^ (seed[11:0] | 12'h001);
    repeat (20) @(negedge clk);
    check("wetting high", wet_high[0], 1'b1);
    repeat (60) @(negedge clk);
    check("int pin", {int_n_oe, int_n_o}, 2'h2);
    check("wetting", wet_high[0], 1'b0);
    host.xfer(cmd, 16, rx);
    check("int status", rx, status(2'h0, 1'b1, sw));
    check("int cleared", int_n_oe, 1'b0);
    host.xfer({4'h1, ~cmd[11:0]}, 15, rx);
    check("short word", run_cfg, cmd[11:0]);
    // Polling, master then slave
    sw = 12'h0;
    repeat (10) @(negedge clk);
    cmd = {4'h1, 2'h1, cmd[9:0]};
    host.xfer(cmd, 16, rx);
    check("old mode", rx[15:14], 2'h0);
    repeat (8) @(negedge clk);
    check("poll mode", mode_code, 2'h1);
    check("master osc", osc_run, 1'b1);
    host.xfer(cmd, 16, rx);
    check("new mode", rx, status(2'h1, 1'b0, 12'h0));
    master = 1'b0;
    sync_pin = 1'b1;
    repeat (10) @(negedge clk);
    check("slave wake", sense_enable, 1'b1);
    sync_pin = 1'b0;
    repeat (10) @(negedge clk);
    check("slave idle", {osc_run, sense_enable}, 2'h0);
    master = 1'b1;
    sw = 12'h020;
    for (n = 0; n < 200 && int_n_oe !== 1'b1; n++) @(negedge clk);
    give_up(n);
    repeat (4) @(negedge clk);
    check("auto normal", mode_code, 2'h0);
    cmd = {4'h1, 2'h0, cmd[9:0]};
    host.xfer(cmd, 16, rx);
    check("poll status", rx, status(2'h0, 1'b1, sw));
    // Chained length words for the input masks
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      host.xfer({k ? 4'h5 : 4'h3, seed[11:0]}, 32, rx);
      check("mask word", k ? metal_cfg : tri_mask, seed[11:0]);
    end
    rst_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    rst_n_pin = 1'b1;
    repeat (6) @(negedge clk);
    check("pin reset", {run_cfg, metal_cfg, tri_mask}, 36'h0);
    check("pin reset out", {wet_high, int_n_oe}, 13'h0);
    host.xfer(16'h0000, 16, rx);
    check("reset status", rx, status(2'h0, 1'b0, 12'h0));
    // Wake by metallic word, sleep again, then timed polling
    host.xfer({4'h5, 12'h000}, 16, rx);
    check("metal wake", {sense_enable, osc_run}, 2'h3);
    host.xfer(16'h0000, 16, rx);
    sw = ~sw;
    repeat (20) @(negedge clk);
    check("sleep quiet", {sense_enable, int_n_oe}, 2'h0);
    sw = 12'h0;
    host.xfer(16'h1800, 16, rx);
    check("timer mode", mode_code, 2'h2);
    for (n = 0; n < 200 && int_n_oe !== 1'b1; n++) @(negedge clk);
    give_up(n);
    host.xfer(16'h1800, 16, rx);
    check("timer status", rx, status(2'h2, 1'b1, 12'h0));
    summarize();
  end
endmodule

`default_nettype wire
